// ### pcg_pkg.sv
package pcg_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH_DEF = 8;
  localparam int ADDR_W     = 8;

  // ****************************************
  // Register byte offsets (bank 0)
  // ****************************************
  localparam logic [7:0] OFF_ENABLE   = 8'h00;
  localparam logic [7:0] OFF_POLARITY = 8'h04;
  localparam logic [7:0] OFF_CLK_SEL  = 8'h08;
  localparam logic [7:0] OFF_CENTER   = 8'h0c;
  localparam logic [7:0] OFF_CONTROL  = 8'h10;
  localparam logic [7:0] OFF_PRESCALE = 8'h14;
  localparam logic [7:0] OFF_SCALE_A  = 8'h18;
  localparam logic [7:0] OFF_SCALE_B  = 8'h1c;

  // Per-channel banks: byte address = bank * 0x20 + channel * 4
  localparam logic [2:0] BANK_REGS    = 3'h0;
  localparam logic [2:0] BANK_COUNTER = 3'h1;
  localparam logic [2:0] BANK_PERIOD  = 3'h2;
  localparam logic [2:0] BANK_DUTY    = 3'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_JOIN_LSB  = 4;
  localparam int CTL_WAIT_BIT  = 3;
  localparam int CTL_FRZ_BIT   = 2;
  localparam int PRE_TAP_A_LSB = 0;
  localparam int PRE_TAP_B_LSB = 4;
  localparam int SRC_SEL_W     = 2;

  // Clock source codes
  localparam logic [1:0] SRC_A        = 2'h0;
  localparam logic [1:0] SRC_B        = 2'h1;
  localparam logic [1:0] SRC_SCALED_A = 2'h2;
  localparam logic [1:0] SRC_SCALED_B = 2'h3;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0] RST_REG8   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_DUTY   = 8'h00;

endpackage

// ### pcg_pair_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcg_pair_if;
  logic        joined;
  logic [1:0]  en;
  logic [1:0]  pol;
  logic [1:0]  center;
  logic [1:0]  tick;
  logic [1:0]  wr_per;
  logic [1:0]  wr_duty;
  logic [1:0]  wr_cnt;
  logic [7:0]  wbyte;
  logic [15:0] cnt;
  logic [15:0] per;
  logic [15:0] duty;
  logic [1:0]  pin;

  modport ctrl (
    output joined, en, pol, center, tick, wr_per, wr_duty, wr_cnt, wbyte,
    input  cnt, per, duty, pin
  );

  modport pair (
    input  joined, en, pol, center, tick, wr_per, wr_duty, wr_cnt, wbyte,
    output cnt, per, duty, pin
  );
endinterface
`default_nettype wire

// ### pcg_pair.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_pair
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controls in, counters and pins out
  pcg_pair_if.pair p
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] per_buf_reg;
  logic [15:0] duty_buf_reg;
  logic [15:0] per_act_reg;
  logic [15:0] duty_act_reg;
  logic [1:0]  dn_reg;
  logic [1:0]  dn_next;
  logic [1:0]  ff_reg;
  logic [1:0]  ff_next;
  logic [1:0]  fin;
  logic [1:0]  ld;
  logic [1:0]  pin_reg;
  logic [17:0] st;

  // Returns {period end, count down, next count}
  function automatic logic [17:0] step(input logic [15:0] c, input logic [15:0] lim,
                                       input logic dn, input logic ca);
    logic [16:0] nx;
    nx = {1'b0, c} + 17'h1;
    if (!ca)
      step = (nx >= {1'b0, lim}) ? 18'h20000 : {2'b00, nx[15:0]};
    else if (!dn)
      step = {1'b0, nx >= {1'b0, lim}, nx[15:0]};
    else if (c <= 16'h1)
      step = 18'h20000;
    else
      step = {2'b01, c - 16'h1};
  endfunction

  // ****************************************
  // Counters and output flip-flops
  // ****************************************
  always_comb
  begin
    cnt_next = cnt_reg;
    dn_next  = dn_reg;
    ff_next  = ff_reg;
    fin      = 2'b00;
    st       = 18'h0;
    if (p.joined)
    begin
      // Odd half's controls steer the merged channel
      st = step(cnt_reg, per_act_reg, dn_reg[1], p.center[1]);
      fin = {2{p.en[1] & p.tick[1] & st[17]}};
      dn_next[0] = 1'b0;
      ff_next[0] = 1'b0;
      if (|p.wr_cnt)
      begin
        cnt_next   = 16'h0;
        dn_next[1] = 1'b0;
        ff_next[1] = 1'b0;
      end
      else if (!p.en[1])
        ff_next[1] = 1'b0;
      else
      begin
        if (p.tick[1])
        begin
          cnt_next   = st[15:0];
          dn_next[1] = st[16];
        end
        if (cnt_next == duty_act_reg)
          ff_next[1] = ~dn_next[1];
        else if (fin[1])
          ff_next[1] = 1'b0;
      end
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        st = step({8'h00, cnt_reg[8*(1-h) +: 8]}, {8'h00, per_act_reg[8*(1-h) +: 8]},
                  dn_reg[h], p.center[h]);
        fin[h] = p.en[h] & p.tick[h] & st[17];
        if (p.wr_cnt[h])
        begin
          cnt_next[8*(1-h) +: 8] = 8'h00;
          dn_next[h] = 1'b0;
          ff_next[h] = 1'b0;
        end
        else if (!p.en[h])
          ff_next[h] = 1'b0;
        else
        begin
          if (p.tick[h])
          begin
            cnt_next[8*(1-h) +: 8] = st[7:0];
            dn_next[h] = st[16];
          end
          // Compare the count being entered, so the edge lands on the match
          if (cnt_next[8*(1-h) +: 8] == duty_act_reg[8*(1-h) +: 8])
            ff_next[h] = ~dn_next[h];
          else if (fin[h])
            ff_next[h] = 1'b0;
        end
      end
    end
  end

  // Active values reload at period end, counter write or while disabled
  assign ld[1] = ~p.en[1] | p.wr_cnt[1] | fin[1] | (p.joined & p.wr_cnt[0]);
  assign ld[0] = p.joined ? ld[1] : (~p.en[0] | p.wr_cnt[0] | fin[0]);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 16'h0;
      dn_reg  <= 2'b00;
      ff_reg  <= 2'b00;
    end
    else
    begin
      cnt_reg <= cnt_next;
      dn_reg  <= dn_next;
      ff_reg  <= ff_next;
    end
  end

  // ****************************************
  // Period and duty, buffer and active latch
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      per_buf_reg  <= {RST_PERIOD, RST_PERIOD};
      duty_buf_reg <= {RST_DUTY, RST_DUTY};
      per_act_reg  <= {RST_PERIOD, RST_PERIOD};
      duty_act_reg <= {RST_DUTY, RST_DUTY};
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        if (p.wr_per[h])
          per_buf_reg[8*(1-h) +: 8] <= p.wbyte;
        if (p.wr_duty[h])
          duty_buf_reg[8*(1-h) +: 8] <= p.wbyte;
        // Disabled: a write lands in both copies at once
        if (ld[h])
        begin
          per_act_reg[8*(1-h) +: 8]  <= p.wr_per[h] ? p.wbyte
                                       : per_buf_reg[8*(1-h) +: 8];
          duty_act_reg[8*(1-h) +: 8] <= p.wr_duty[h] ? p.wbyte
                                       : duty_buf_reg[8*(1-h) +: 8];
        end
      end
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_reg <= 2'b00;
    else
    begin
      pin_reg[1] <= ff_reg[1] ^ p.pol[1];
      pin_reg[0] <= p.joined ? 1'b0 : (ff_reg[0] ^ p.pol[0]);
    end
  end

  assign p.cnt  = cnt_reg;
  assign p.per  = per_buf_reg;
  assign p.duty = duty_buf_reg;
  assign p.pin  = pin_reg;

endmodule // pcg_pair
`default_nettype wire

// ### pcg_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System operating modes
  input  wire logic              wait_mode,
  input  wire logic              freeze_mode,
  // Channel pins
  output wire logic [NUM_CH-1:0] output_port
);

  localparam int NPAIR = NUM_CH / 2;
  localparam int CS_W  = SRC_SEL_W * NUM_CH;

  // ****************************************
  // Register state
  // ****************************************
  logic [NUM_CH-1:0] channel_enable_bit;
  logic [NUM_CH-1:0] polarity_reg;
  logic [NUM_CH-1:0] center_reg;
  logic [CS_W-1:0]   clock_source_select_reg;
  logic [NPAIR-1:0]  join_reg;
  logic              wait_stop_bit;
  logic              freeze_stop_bit;
  logic [7:0]        prescale_reg;
  logic [7:0]        scale_reg [2];
  logic [31:0]       prdata_reg;
  logic              err_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [2:0]  bank;
  logic [2:0]  chan;
  logic        wr_en;
  logic        bank_wr;
  logic        chan_ok;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic [7:0]  pwm_control_reg;
  logic [7:0]  cnt_byte  [NUM_CH];
  logic [7:0]  per_byte  [NUM_CH];
  logic [7:0]  duty_byte [NUM_CH];

  assign bank    = paddr[7:5];
  assign chan    = paddr[4:2];
  assign chan_ok = int'(chan) < NUM_CH;
  // Zero wait states: a write commits in the access cycle
  assign wr_en   = psel & penable & pwrite;
  assign bank_wr = wr_en & pstrb[0] & (paddr[1:0] == 2'h0);

  // Control register view; bits of absent pairs stay zero
  always_comb
  begin
    pwm_control_reg = RST_REG8;
    pwm_control_reg[CTL_JOIN_LSB +: NPAIR] = join_reg;
    pwm_control_reg[CTL_WAIT_BIT] = wait_stop_bit;
    pwm_control_reg[CTL_FRZ_BIT]  = freeze_stop_bit;
  end

  always_comb
  begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    if (paddr[1:0] != 2'h0)
      rd_ok = 1'b0;
    else if (bank == BANK_REGS)
    begin
      case (paddr)
        OFF_ENABLE:   rd_data[NUM_CH-1:0] = channel_enable_bit;
        OFF_POLARITY: rd_data[NUM_CH-1:0] = polarity_reg;
        OFF_CLK_SEL:  rd_data[CS_W-1:0]   = clock_source_select_reg;
        OFF_CENTER:   rd_data[NUM_CH-1:0] = center_reg;
        OFF_CONTROL:  rd_data[7:0]        = pwm_control_reg;
        OFF_PRESCALE: rd_data[7:0]        = prescale_reg;
        OFF_SCALE_A:  rd_data[7:0]        = scale_reg[0];
        OFF_SCALE_B:  rd_data[7:0]        = scale_reg[1];
        default:      rd_ok = 1'b0;
      endcase
    end
    else if (chan_ok)
    begin
      case (bank)
        BANK_COUNTER: rd_data[7:0] = cnt_byte[chan];
        BANK_PERIOD:  rd_data[7:0] = per_byte[chan];
        BANK_DUTY:    rd_data[7:0] = duty_byte[chan];
        default:      rd_ok = 1'b0;
      endcase
    end
    else
      rd_ok = 1'b0;
  end

  // Read data is caught in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_reg <= 32'h0;
      err_reg    <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_reg <= pwrite ? 32'h0 : rd_data;
      err_reg    <= ~rd_ok;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = err_reg & psel & penable;

  // ****************************************
  // Register writes
  // ****************************************
  // Vectors hold only implemented channels, so writes to the rest vanish
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      channel_enable_bit <= '0;
      polarity_reg       <= '0;
      center_reg         <= '0;
    end
    else if (bank_wr && bank == BANK_REGS)
    begin
      if (paddr == OFF_ENABLE)
        channel_enable_bit <= pwdata[NUM_CH-1:0];
      if (paddr == OFF_POLARITY)
        polarity_reg <= pwdata[NUM_CH-1:0];
      if (paddr == OFF_CENTER)
        center_reg <= pwdata[NUM_CH-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clock_source_select_reg <= '0;
    else if (wr_en && paddr == OFF_CLK_SEL)
    begin
      for (int b = 0; b < CS_W; b++)
      begin
        if (pstrb[b/8])
          clock_source_select_reg[b] <= pwdata[b];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      join_reg        <= '0;
      wait_stop_bit   <= 1'b0;
      freeze_stop_bit <= 1'b0;
    end
    else if (bank_wr && paddr == OFF_CONTROL)
    begin
      join_reg        <= pwdata[CTL_JOIN_LSB +: NPAIR];
      wait_stop_bit   <= pwdata[CTL_WAIT_BIT];
      freeze_stop_bit <= pwdata[CTL_FRZ_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prescale_reg <= RST_REG8;
      scale_reg[0] <= RST_REG8;
      scale_reg[1] <= RST_REG8;
    end
    else if (bank_wr)
    begin
      if (paddr == OFF_PRESCALE)
        prescale_reg <= pwdata[7:0];
      if (paddr == OFF_SCALE_A)
        scale_reg[0] <= pwdata[7:0];
      if (paddr == OFF_SCALE_B)
        scale_reg[1] <= pwdata[7:0];
    end
  end

  // ****************************************
  // Prescaler and clock sources
  // ****************************************
  logic       pre_run;
  logic [6:0] pre_cnt_reg;
  logic [2:0] tap [2];
  logic [3:0] src_tick;
  logic [8:0] sc_cnt_reg [2];
  logic [9:0] sc_lim [2];

  function automatic logic [6:0] tap_mask(input logic [2:0] t);
    logic [7:0] m;
    m = (8'h1 << t) - 8'h1;
    tap_mask = m[6:0];
  endfunction

  // Mode inputs come from logic on this clock, so no synchroniser
  assign pre_run = ~(wait_mode & wait_stop_bit)
                 & ~(freeze_mode & freeze_stop_bit);
  assign tap[0]  = prescale_reg[PRE_TAP_A_LSB +: 3];
  assign tap[1]  = prescale_reg[PRE_TAP_B_LSB +: 3];

  always_ff @(posedge clk)
  begin
    if (rst)
      pre_cnt_reg <= 7'h0;
    else if (pre_run)
      pre_cnt_reg <= pre_cnt_reg + 7'h1;
  end

  // Sources A/B divide by 2^tap; scaled ones by a further 2*scale, or 512 when scale is 0
  for (genvar s = 0; s < 2; s++)
  begin : g_src
    assign src_tick[s] = pre_run & ((pre_cnt_reg & tap_mask(tap[s])) == 7'h0);
    assign sc_lim[s]   = (scale_reg[s] == 8'h00) ? 10'h200 : {1'b0, scale_reg[s], 1'b0};
    assign src_tick[2+s] = src_tick[s] & ({1'b0, sc_cnt_reg[s]} == sc_lim[s] - 10'h1);

    always_ff @(posedge clk)
    begin
      if (rst)
        sc_cnt_reg[s] <= 9'h0;
      else if (src_tick[2+s])
        sc_cnt_reg[s] <= 9'h0;
      else if (src_tick[s])
        sc_cnt_reg[s] <= sc_cnt_reg[s] + 9'h1;
    end
  end

  // ****************************************
  // Channel pairs
  // ****************************************
  for (genvar i = 0; i < NPAIR; i++)
  begin : g_pair
    pcg_pair_if pif ();

    assign pif.joined = join_reg[i];
    assign pif.en     = channel_enable_bit[2*i +: 2];
    assign pif.pol    = polarity_reg[2*i +: 2];
    assign pif.center = center_reg[2*i +: 2];
    assign pif.wbyte  = pwdata[7:0];

    for (genvar h = 0; h < 2; h++)
    begin : g_half
      // Each channel picks one of the four source ticks
      assign pif.tick[h] = src_tick[clock_source_select_reg[SRC_SEL_W*(2*i+h) +: 2]];
      assign pif.wr_cnt[h]  = bank_wr & (bank == BANK_COUNTER)
                            & (chan == 3'(2*i+h));
      assign pif.wr_per[h]  = bank_wr & (bank == BANK_PERIOD)
                            & (chan == 3'(2*i+h));
      assign pif.wr_duty[h] = bank_wr & (bank == BANK_DUTY)
                            & (chan == 3'(2*i+h));
    end

    // Even channel holds the high byte of a joined pair
    assign cnt_byte[2*i]    = pif.cnt[15:8];
    assign cnt_byte[2*i+1]  = pif.cnt[7:0];
    assign per_byte[2*i]    = pif.per[15:8];
    assign per_byte[2*i+1]  = pif.per[7:0];
    assign duty_byte[2*i]   = pif.duty[15:8];
    assign duty_byte[2*i+1] = pif.duty[7:0];
    assign output_port[2*i +: 2] = pif.pin;

    pcg_pair u_pair (
      .clk (clk),
      .rst (rst),
      .p   (pif.pair)
    );
  end

endmodule // pcg_top
`default_nettype wire

// ### pcg_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_chk
  import pcg_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
)
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // APB slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Modes and pins
  input wire logic              wait_mode,
  input wire logic              freeze_mode,
  input wire logic [NUM_CH-1:0] output_port
);
  // ****************************************
  // Shadow of the control register
  // ****************************************
  function automatic logic [7:0] ctl_mask_f();
    logic [7:0] m;
    m = 8'h0c;
    for (int k = 0; k < 4; k++)
      if (2 * k + 1 < NUM_CH) m[4+k] = 1'b1;
    return m;
  endfunction
  localparam logic [7:0] CTL_MASK = ctl_mask_f();

  logic [7:0]        ctl_reg;
  logic [NUM_CH-1:0] even_mask;
  logic              halted;

  always_ff @(posedge clk)
  begin
    if (rst) ctl_reg <= 8'h00;
    else if (psel && penable && pwrite && paddr == OFF_CONTROL && pstrb[0])
      ctl_reg <= pwdata[7:0] & CTL_MASK;
  end

  always_comb
  begin
    even_mask = '0;
    for (int k = 0; k < NUM_CH / 2; k++)
      if (ctl_reg[CTL_JOIN_LSB+k]) even_mask[2*k] = 1'b1;
  end

  // Prescaler input stopped: no counter may move, so pins must settle
  assign halted = (freeze_mode && ctl_reg[CTL_FRZ_BIT]) || (wait_mode && ctl_reg[CTL_WAIT_BIT]);

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_bad_setup;
    psel && !penable && (paddr[1:0] != 2'b00 || paddr[7]);
  endsequence

  chk_bad_addr_err: assert property (s_bad_setup ##1 s_access |-> pslverr)
    else $error("unmapped access without error");
  chk_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_bad_read_zero: assert property ((s_bad_setup ##0 !pwrite) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_absent_en_zero: assert property ((s_setup ##0 (!pwrite && paddr == OFF_ENABLE))
    |=> (prdata >> NUM_CH) == 32'h0)
    else $error("absent enable bits read nonzero");
  chk_ctl_readback: assert property ((s_setup ##0 (!pwrite && paddr == OFF_CONTROL))
    |=> prdata[31:2] == {24'h0, ctl_reg[7:2]})
    else $error("control readback mismatch");
  chk_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");
  chk_halt_pins: assert property ((halted && !psel) [*6] |-> $stable(output_port))
    else $error("pins moved with prescaler stopped");
  chk_even_pin_low: assert property ((even_mask != '0 && $stable(even_mask)) [*4]
    |-> (output_port & even_mask) == '0)
    else $error("even pin of joined pair driven");
  chk_reset_pins: assert property ($fell(rst) |-> output_port == '0)
    else $error("pins not low after reset");
endmodule // pcg_chk

bind pcg_top pcg_chk #(.NUM_CH(NUM_CH)) chk_u (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wait_mode(wait_mode), .freeze_mode(freeze_mode), .output_port(output_port)
);
`default_nettype wire

// ### pcg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_top_tb;
  import pcg_pkg::*;
  // Six channels so that pair 6/7 is absent
  localparam int NCH = 6;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic              wait_mode, freeze_mode;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat, c0;
  logic [3:0]        pstrb;
  wire logic [NCH-1:0] pins;
  int n_errors = 0, check_count = 0, cyc = 0, hi, rs;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  pcg_top #(.NUM_CH(NCH)) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_mode(wait_mode), .freeze_mode(freeze_mode), .output_port(pins)
  );

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  function automatic logic [7:0] ad(input logic [2:0] b, input int ch);
    return {b, 3'(ch), 2'b00};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkn(input string nm, input int e, input int g, input int tol);
    check_count++;
    if (g + tol < e || g > e + tol)
    begin
      n_errors++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Counts high cycles and rising edges of one pin
  task meas(input int ch, input int n);
    logic prev;
    hi = 0;
    rs = 0;
    @(posedge clk);
    prev = pins[ch];
    repeat (n)
    begin
      @(posedge clk);
      if (pins[ch] === 1'b1) hi++;
      if (prev === 1'b0 && pins[ch] === 1'b1) rs++;
      prev = pins[ch];
    end
  endtask
  task run(input int ch, input logic [7:0] p, input logic [7:0] d);
    wr(OFF_ENABLE, 32'h0);
    wr(ad(BANK_PERIOD, ch), {24'h0, p});
    wr(ad(BANK_DUTY, ch), {24'h0, d});
    wr(OFF_ENABLE, 32'h1 << ch);
    repeat (8) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs();
    chk("reset pins", 32'h0, 32'(pins));
    rd(ad(BANK_PERIOD, 0)); chk("period reset", {24'h0, RST_PERIOD}, rdat);
    wr(OFF_ENABLE, 32'hff); rd(OFF_ENABLE); chk("enable", 32'h3f, rdat);
    wr(OFF_CONTROL, 32'hfc); rd(OFF_CONTROL); chk("control", 32'h7c, rdat);
    wr(OFF_CONTROL, 32'h0); wr(OFF_ENABLE, 32'h0);
    rd(ad(BANK_COUNTER, 6)); chk("absent counter err", 32'h1, 32'(rerr));
    wr(8'h80, 32'h1); chk("unmapped write err", 32'h1, 32'(rerr));
  endtask
  task t_wave();
    int dv[4];
    dv = '{1, 2, 2, 4};
    for (int pol = 0; pol < 2; pol++)
    begin
      wr(OFF_POLARITY, 32'(pol)); run(0, 8'h04, 8'h01); meas(0, 128);
      chkn("left high time", pol ? 32 : 96, hi, 0);
      chkn("left periods", 32, rs, 1);
    end
    wr(OFF_PRESCALE, 32'h10); wr(OFF_SCALE_A, 32'h1); wr(OFF_SCALE_B, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFF_CLK_SEL, 32'(s)); run(0, 8'h04, 8'h01); meas(0, 256);
      chkn("source rate", 64 / dv[s], rs, 1);
    end
    wr(OFF_CLK_SEL, 32'h0); wr(OFF_PRESCALE, 32'h0);
    wr(OFF_CENTER, 32'h1); run(0, 8'h04, 8'h01); meas(0, 128);
    chkn("center periods", 16, rs, 1);
    chkn("center high time", 32, hi, 4);
    wr(OFF_CENTER, 32'h0);
  endtask
  task t_buffer();
    run(0, 8'hc8, 8'h64);
    wr(ad(BANK_COUNTER, 0), 32'h0); wr(ad(BANK_DUTY, 0), 32'ha);
    rd(ad(BANK_DUTY, 0)); chk("duty buffer", 32'ha, rdat);
    repeat (30) @(posedge clk);
    chk("old duty kept", 32'h1, 32'(pins[0]));
    wr(ad(BANK_COUNTER, 0), 32'h55); rd(ad(BANK_COUNTER, 0));
    chk("counter cleared", 32'h1, 32'(rdat < 32'd4));
    repeat (30) @(posedge clk);
    chk("new duty latched", 32'h0, 32'(pins[0]));
    wr(OFF_ENABLE, 32'h0); rd(ad(BANK_COUNTER, 0)); c0 = rdat;
    repeat (10) @(posedge clk);
    rd(ad(BANK_COUNTER, 0)); chk("disabled count", c0, rdat);
    chk("disabled pin", 32'h1, 32'(pins[0]));
  endtask
  task t_join();
    // Even channel set to idle high, so only the join can hold its pin low
    wr(OFF_POLARITY, 32'h3); wr(OFF_CONTROL, 32'h10);
    wr(ad(BANK_PERIOD, 0), 32'h1); wr(ad(BANK_DUTY, 0), 32'h0);
    run(1, 8'h00, 8'h40); meas(1, 512);
    chkn("joined high time", 128, hi, 0);
    chk("even pin", 32'h0, 32'(pins[0]));
    wr(OFF_CONTROL, 32'h0);
  endtask
  task t_halt();
    wr(OFF_POLARITY, 32'h1); run(0, 8'h04, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      wr(OFF_CONTROL, 32'h1 << (m ? CTL_WAIT_BIT : CTL_FRZ_BIT));
      wait_mode <= 1'(m); freeze_mode <= 1'(1 - m);
      // Let the pin pipeline drain before counting edges
      repeat (4) @(posedge clk);
      meas(0, 64); chkn("stopped periods", 0, rs, 0);
      wr(OFF_CONTROL, 32'h0); repeat (8) @(posedge clk);
      meas(0, 64); chkn("running periods", 16, rs, 1);
      wait_mode <= 1'b0; freeze_mode <= 1'b0;
    end
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      $display("[ERR] run time expected below %0d cycles seen %0d", 20000, cyc);
      results();
    end
  end

  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hf; wait_mode = 1'b0; freeze_mode = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_wave();
    t_buffer();
    t_join();
    t_halt();
    results();
  end
endmodule // pcg_top_tb
`default_nettype wire
